// ===== include/sccp_pkg.sv
// package for the system control coprocessor register bank and its cache
// assumes a single core clock; shared by the design and the bench
package sccp_pkg;

  // register numbers seen on the transfer port
  localparam logic [3:0] REG_CHIP_IDENTITY = 4'h0;
  localparam logic [3:0] REG_SYSTEM_CONTROL = 4'h1;
  localparam logic [3:0] REG_TRANSLATION_TABLE_BASE = 4'h2;
  localparam logic [3:0] REG_DOMAIN_ACCESS_CONTROL = 4'h3;
  localparam logic [3:0] REG_RESERVED_SLOT_FOUR = 4'h4;
  localparam logic [3:0] REG_FAULT_STATUS_TLB_FLUSH = 4'h5;
  localparam logic [3:0] REG_FAULT_ADDRESS_TLB_PURGE = 4'h6;
  localparam logic [3:0] REG_CACHE_INVALIDATE_ALL = 4'h7;
  localparam int REG_NUM_HIGH_BIT = 3;

  // identity value: arbitrary, names no real maker or part
  localparam logic [31:0] CHIP_IDENTITY_VALUE = 32'h5A5A_0010;

  // control field positions
  localparam int CTRL_MMU_BIT = 0;
  localparam int CTRL_ALIGN_BIT = 1;
  localparam int CTRL_CACHE_BIT = 2;
  localparam int CTRL_WBUF_BIT = 3;
  localparam int CTRL_PROG32_BIT = 4;
  localparam int CTRL_DATA32_BIT = 5;
  localparam int CTRL_BIGEND_BIT = 7;
  localparam int CTRL_SYSTEM_BIT = 8;
  localparam int CTRL_ROM_BIT = 9;

  // reset values and the fault status read mask
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [7:0] LFSR_SEED = 8'h01;
  localparam logic [31:0] FAULT_STATUS_MASK = 32'h0000_00FF;

  // cache geometry
  localparam int CACHE_LINES = 512;
  localparam int CACHE_WAYS = 4;
  localparam int SET_W = 7;
  localparam int TAG_W = 21;
  localparam int WORD_SEL_W = 2;
  localparam int WAY_W = 2;
  localparam int DATA_WORDS = 2048;
  localparam logic [1:0] LAST_WORD = 2'h3;

  // one coprocessor register transfer from the core
  typedef struct packed {
    logic valid;
    logic write;
    logic user_mode;
    logic [3:0] num;
    logic [31:0] data;
  } sccp_xfer_s;

  // decoded control bits
  typedef struct packed {
    logic rom;
    logic system;
    logic big_endian;
    logic data32;
    logic prog32;
    logic wbuf_en;
    logic cache_en;
    logic align_en;
    logic mmu_en;
  } sccp_ctrl_s;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FILL = 3'b010,
    ST_SINGLE = 3'b100
  } sccp_state_e;

endpackage

// ===== rtl/sccp_regs.sv
// system control coprocessor registers plus the unified cache they steer
// assumes the core, fault logic and memory port all run on clock_i
`timescale 1ns/100ps
module sccp_regs
  import sccp_pkg::*;
(
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire sccp_xfer_s xfer_i,
  output logic xfer_done_o,
  output logic xfer_undef_o,
  output logic [31:0] xfer_rdata_o,
  output sccp_ctrl_s ctrl_o,
  output logic [31:0] ttb_o,
  output logic [31:0] dac_o,
  output logic tlb_flush_o,
  output logic tlb_purge_o,
  output logic [31:0] tlb_purge_addr_o,
  input wire logic dfault_i,
  input wire logic dfault_prefetch_i,
  input wire logic [7:0] dfault_status_i,
  input wire logic [31:0] dfault_addr_i,
  input wire logic rd_valid_i,
  input wire logic [31:0] rd_addr_i,
  input wire logic rd_cacheable_i,
  output logic rd_ready_o,
  output logic rd_done_o,
  output logic [31:0] rd_data_o,
  output logic mem_req_o,
  output logic mem_line_o,
  output logic [31:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i
);

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!arst_n_i);

  ////////////////////////////////////////////////////////////////////////////
  // register file

  logic [31:0] ctrl_reg, ctrl_next;
  logic [31:0] ttb_reg, ttb_next;
  logic [31:0] dac_reg, dac_next;
  logic [31:0] fsr_reg, fsr_next;
  logic [31:0] far_reg, far_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] purge_addr_reg, purge_addr_next;
  logic done_reg, done_next;
  logic undef_reg, undef_next;
  logic tflush_reg, tflush_next;
  logic purge_reg, purge_next;
  logic cache_flush;
  logic priv_ok;

  assign priv_ok = xfer_i.valid && !xfer_i.user_mode && !xfer_i.num[REG_NUM_HIGH_BIT];

  // decode one transfer per cycle; the answer comes one cycle later
  always_comb begin
    ctrl_next = ctrl_reg;
    ttb_next = ttb_reg;
    dac_next = dac_reg;
    fsr_next = fsr_reg;
    far_next = far_reg;
    rdata_next = rdata_reg;
    purge_addr_next = purge_addr_reg;
    done_next = 1'b0;
    undef_next = 1'b0;
    tflush_next = 1'b0;
    purge_next = 1'b0;
    cache_flush = 1'b0;
    if (xfer_i.valid && !priv_ok) begin
      undef_next = 1'b1;
    end else if (priv_ok) begin
      done_next = 1'b1;
      if (xfer_i.write) begin
        case (xfer_i.num)
          REG_SYSTEM_CONTROL: ctrl_next = xfer_i.data;
          REG_TRANSLATION_TABLE_BASE: ttb_next = xfer_i.data;
          REG_DOMAIN_ACCESS_CONTROL: dac_next = xfer_i.data;
          REG_FAULT_STATUS_TLB_FLUSH: tflush_next = 1'b1;
          REG_FAULT_ADDRESS_TLB_PURGE: begin
            purge_next = 1'b1;
            purge_addr_next = xfer_i.data;
          end
          REG_CACHE_INVALIDATE_ALL: cache_flush = 1'b1;
          default: ; // identity and slot four writes do nothing
        endcase
      end else begin
        case (xfer_i.num)
          REG_CHIP_IDENTITY: rdata_next = CHIP_IDENTITY_VALUE;
          REG_FAULT_STATUS_TLB_FLUSH: rdata_next = fsr_reg & FAULT_STATUS_MASK;
          REG_FAULT_ADDRESS_TLB_PURGE: rdata_next = far_reg;
          default: rdata_next = WORD_RESET;
        endcase
      end
    end
    // prefetch faults leave the saved status alone
    if (dfault_i && !dfault_prefetch_i) begin
      fsr_next = {24'h00_0000, dfault_status_i};
      far_next = dfault_addr_i;
    end
  end

  // register stage; everything clears on reset
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_reg <= WORD_RESET;
      ttb_reg <= WORD_RESET;
      dac_reg <= WORD_RESET;
      fsr_reg <= WORD_RESET;
      far_reg <= WORD_RESET;
      rdata_reg <= WORD_RESET;
      purge_addr_reg <= WORD_RESET;
      done_reg <= 1'b0;
      undef_reg <= 1'b0;
      tflush_reg <= 1'b0;
      purge_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      ttb_reg <= ttb_next;
      dac_reg <= dac_next;
      fsr_reg <= fsr_next;
      far_reg <= far_next;
      rdata_reg <= rdata_next;
      purge_addr_reg <= purge_addr_next;
      done_reg <= done_next;
      undef_reg <= undef_next;
      tflush_reg <= tflush_next;
      purge_reg <= purge_next;
    end
  end

  assign xfer_done_o = done_reg;
  assign xfer_undef_o = undef_reg;
  assign xfer_rdata_o = rdata_reg;
  assign ttb_o = ttb_reg;
  assign dac_o = dac_reg;
  assign tlb_flush_o = tflush_reg;
  assign tlb_purge_o = purge_reg;
  assign tlb_purge_addr_o = purge_addr_reg;

  // decoded control bits for the translation unit, buffer and core
  assign ctrl_o.mmu_en = ctrl_reg[CTRL_MMU_BIT];
  assign ctrl_o.align_en = ctrl_reg[CTRL_ALIGN_BIT];
  assign ctrl_o.cache_en = ctrl_reg[CTRL_CACHE_BIT];
  assign ctrl_o.wbuf_en = ctrl_reg[CTRL_WBUF_BIT];
  assign ctrl_o.prog32 = ctrl_reg[CTRL_PROG32_BIT];
  assign ctrl_o.data32 = ctrl_reg[CTRL_DATA32_BIT];
  assign ctrl_o.big_endian = ctrl_reg[CTRL_BIGEND_BIT];
  assign ctrl_o.system = ctrl_reg[CTRL_SYSTEM_BIT];
  assign ctrl_o.rom = ctrl_reg[CTRL_ROM_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // unified cache: 128 sets x 4 ways x 4 words

  logic [31:0] data_mem [0:DATA_WORDS-1];
  logic [TAG_W-1:0] tag_mem [0:CACHE_LINES-1];
  logic [CACHE_LINES-1:0] valid_reg, valid_next;
  sccp_state_e state_reg, state_next;
  logic [27:0] line_reg, line_next;
  logic [1:0] cnt_reg, cnt_next;
  logic [1:0] word_reg, word_next;
  logic [1:0] way_reg, way_next;
  logic [7:0] lfsr_reg, lfsr_next;
  logic [31:0] rd_data_reg, rd_data_next;
  logic rd_done_reg, rd_done_next;
  logic fill_we, set_valid, hit;
  logic [1:0] hit_way;
  logic [SET_W-1:0] look_set, fill_set;

  assign look_set = rd_addr_i[10:4];
  assign fill_set = line_reg[SET_W-1:0];

  // lookup ignores both enables so stale hits stay usable
  always_comb begin
    hit = 1'b0;
    hit_way = 2'h0;
    for (int w = 0; w < CACHE_WAYS; w++) begin
      if (valid_reg[{2'(w), look_set}] &&
          tag_mem[{2'(w), look_set}] == rd_addr_i[31:11]) begin
        hit = 1'b1;
        hit_way = 2'(w);
      end
    end
  end

  // miss handling: a line fill or one uncached word
  always_comb begin
    state_next = state_reg;
    line_next = line_reg;
    cnt_next = cnt_reg;
    word_next = word_reg;
    way_next = way_reg;
    rd_data_next = rd_data_reg;
    rd_done_next = 1'b0;
    fill_we = 1'b0;
    set_valid = 1'b0;
    valid_next = valid_reg;
    lfsr_next = {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
    case (state_reg)
      ST_IDLE: begin
        if (rd_valid_i) begin
          line_next = rd_addr_i[31:4];
          word_next = rd_addr_i[3:2];
          if (hit) begin
            rd_done_next = 1'b1;
            rd_data_next = data_mem[{hit_way, look_set, rd_addr_i[3:2]}];
          end else if (rd_cacheable_i && ctrl_reg[CTRL_CACHE_BIT]) begin
            state_next = ST_FILL;
            cnt_next = 2'h0;
            way_next = lfsr_reg[1:0];
          end else begin
            state_next = ST_SINGLE;
            cnt_next = rd_addr_i[3:2];
          end
        end
      end
      ST_FILL: begin
        if (mem_ack_i) begin
          fill_we = 1'b1;
          cnt_next = cnt_reg + 2'h1;
          if (cnt_reg == word_reg) begin
            rd_data_next = mem_rdata_i;
          end
          if (cnt_reg == LAST_WORD) begin
            set_valid = 1'b1;
            rd_done_next = 1'b1;
            state_next = ST_IDLE;
          end
        end
      end
      ST_SINGLE: begin
        if (mem_ack_i) begin
          rd_data_next = mem_rdata_i;
          rd_done_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
    // a flush wins over a fill finishing alongside; a fill still in progress sets its line valid after the flush
    if (cache_flush) begin
      valid_next = '0;
    end else if (set_valid) begin
      valid_next[{way_reg, fill_set}] = 1'b1;
    end
  end

  // control flops of the cache; a flush beats a fill finishing alongside
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= ST_IDLE;
      line_reg <= 28'h000_0000;
      cnt_reg <= 2'h0;
      word_reg <= 2'h0;
      way_reg <= 2'h0;
      lfsr_reg <= LFSR_SEED;
      rd_data_reg <= WORD_RESET;
      rd_done_reg <= 1'b0;
      valid_reg <= '0;
    end else begin
      state_reg <= state_next;
      line_reg <= line_next;
      cnt_reg <= cnt_next;
      word_reg <= word_next;
      way_reg <= way_next;
      lfsr_reg <= lfsr_next;
      rd_data_reg <= rd_data_next;
      rd_done_reg <= rd_done_next;
      valid_reg <= valid_next;
    end
  end

  // storage arrays hold no reset; valid bits guard them
  always_ff @(posedge clock_i) begin
    if (fill_we) begin
      data_mem[{way_reg, fill_set, cnt_reg}] <= mem_rdata_i;
    end
    if (set_valid) begin
      tag_mem[{way_reg, fill_set}] <= line_reg[27:7];
    end
  end

  assign rd_ready_o = (state_reg == ST_IDLE);
  assign rd_done_o = rd_done_reg;
  assign rd_data_o = rd_data_reg;
  assign mem_req_o = (state_reg != ST_IDLE);
  assign mem_line_o = (state_reg == ST_FILL);
  assign mem_addr_o = {line_reg, cnt_reg, 2'b00};

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_user_trap: assert property (xfer_i.valid && xfer_i.user_mode
    |=> xfer_undef_o && !xfer_done_o)
    else $error("user mode transfer not trapped");
  a_high_reg_trap: assert property (xfer_i.valid && xfer_i.num[3]
    |=> xfer_undef_o && !tlb_flush_o && !tlb_purge_o)
    else $error("high register number not trapped");
  a_unused_quiet: assert property (priv_ok && xfer_i.num == 4'h4
    |=> xfer_done_o && !xfer_undef_o && !tlb_flush_o && !tlb_purge_o)
    else $error("slot four access had an effect");
  a_id_read: assert property (priv_ok && !xfer_i.write && xfer_i.num == 4'h0
    |=> xfer_rdata_o == CHIP_IDENTITY_VALUE)
    else $error("identity read wrong");
  a_ctrl_bits: assert property (priv_ok && xfer_i.write && xfer_i.num == 4'h1
    |=> ctrl_o.mmu_en == $past(xfer_i.data[0]) && ctrl_o.align_en == $past(xfer_i.data[1])
        && ctrl_o.cache_en == $past(xfer_i.data[2]) && ctrl_o.wbuf_en == $past(xfer_i.data[3]))
    else $error("control enables not taken");
  a_ctrl_space: assert property (priv_ok && xfer_i.write && xfer_i.num == 4'h1
    |=> ctrl_o.prog32 == $past(xfer_i.data[4]) && ctrl_o.data32 == $past(xfer_i.data[5])
        && ctrl_o.big_endian == $past(xfer_i.data[7]))
    else $error("control space bits not taken");
  a_table_store: assert property (priv_ok && xfer_i.write && xfer_i.num == 4'h2
    |=> ttb_o == $past(xfer_i.data) ##1 ttb_o == $past(xfer_i.data, 2) || $past(priv_ok))
    else $error("table base not stored");
  a_domain_store: assert property (priv_ok && xfer_i.write && xfer_i.num == 4'h3
    |=> dac_o == $past(xfer_i.data))
    else $error("domain access not stored");
  a_fsr_read: assert property (priv_ok && !xfer_i.write && xfer_i.num == 4'h5
    |=> xfer_rdata_o[31:8] == 24'h00_0000)
    else $error("fault status upper bits not zero");
  a_tlb_flush: assert property (priv_ok && xfer_i.write && xfer_i.num == 4'h5
    |=> tlb_flush_o && !tlb_purge_o ##1 !tlb_flush_o || $past(priv_ok))
    else $error("tlb flush pulse wrong");
  a_far_read: assert property (dfault_i && !dfault_prefetch_i ##1
    !(dfault_i && !dfault_prefetch_i) ##1
    (priv_ok && !xfer_i.write && xfer_i.num == 4'h6 && !dfault_i)
    |=> xfer_rdata_o == $past(dfault_addr_i, 3))
    else $error("fault address readback wrong");
  a_tlb_purge: assert property (priv_ok && xfer_i.write && xfer_i.num == 4'h6
    |=> tlb_purge_o && tlb_purge_addr_o == $past(xfer_i.data) && !tlb_flush_o)
    else $error("tlb purge wrong");
  a_cache_flush: assert property (priv_ok && xfer_i.write && xfer_i.num == 4'h7
    |=> valid_reg == '0)
    else $error("cache not invalidated");
  a_hit_used: assert property (state_reg == ST_IDLE && rd_valid_i && hit
    |=> rd_done_o && !mem_req_o)
    else $error("cache hit went to memory");
  a_uncached_read: assert property (state_reg == ST_IDLE && rd_valid_i && !hit
    && !(rd_cacheable_i && ctrl_o.cache_en) |=> mem_req_o && !mem_line_o)
    else $error("uncached read filled a line");
  a_fill_words: assert property (state_reg == ST_FILL && mem_ack_i && cnt_reg == 2'h3
    |=> rd_done_o && state_reg == ST_IDLE && valid_reg[{$past(way_reg), $past(fill_set)}]
        || $past(cache_flush))
    else $error("line fill did not complete");

  c_line_fill: cover property (state_reg == ST_FILL ##[1:20] set_valid);
  c_hit: cover property (rd_valid_i && hit && state_reg == ST_IDLE);
  c_trap: cover property (xfer_undef_o);
  c_flush_during_fill: cover property (state_reg == ST_FILL && cache_flush);

endmodule

// ===== testbench/sccp_mem_model.sv
// external memory model on the far side of the cache read port
// assumes one request at a time and a word address that holds until acknowledged
`timescale 1ns/100ps
module sccp_mem_model (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic slow_i,
  input wire logic mem_req_i,
  input wire logic [31:0] mem_addr_i,
  output logic mem_ack_o,
  output logic [31:0] mem_rdata_o
);
  logic [1:0] wait_reg;

  // one ack pulse per beat; the data bus toggles when no beat is valid,
  // so a stale word is never mistaken for a good one
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem_ack_o <= 1'b0;
      wait_reg <= 2'h0;
      mem_rdata_o <= 32'h0000_0000;
    end else if (!mem_req_i || mem_ack_o) begin
      mem_ack_o <= 1'b0;
      wait_reg <= slow_i ? 2'h3 : 2'h0;
      mem_rdata_o <= ~mem_rdata_o;
    end else if (wait_reg != 2'h0) begin
      wait_reg <= wait_reg - 2'h1;
      mem_rdata_o <= ~mem_rdata_o;
    end else begin
      mem_ack_o <= 1'b1;
      mem_rdata_o <= {mem_addr_i[15:0], ~mem_addr_i[15:0]};
    end
  end
endmodule

// ===== testbench/tb_sysctrl_coproc_registers.sv
// self-checking bench for the coprocessor register bank and its cache
// assumes the memory model answers every beat; a shadow model predicts results
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb_sysctrl_coproc_registers;
  import sccp_pkg::*;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  sccp_xfer_s xfer_i = '0;
  logic xfer_done_o, xfer_undef_o, tlb_flush_o, tlb_purge_o;
  logic [31:0] xfer_rdata_o, ttb_o, dac_o, tlb_purge_addr_o, rd_data_o, mem_addr_o, mem_rdata_i;
  sccp_ctrl_s ctrl_o;
  logic dfault_i = 1'b0;
  logic dfault_prefetch_i = 1'b0;
  logic [7:0] dfault_status_i = 8'h00;
  logic [31:0] dfault_addr_i = 32'h0000_0000;
  logic rd_valid_i = 1'b0;
  logic [31:0] rd_addr_i = 32'h0000_0000;
  logic rd_cacheable_i = 1'b0;
  logic rd_ready_o, rd_done_o, mem_req_o, mem_line_o, mem_ack_i;
  logic slow = 1'b0;
  int fail_count = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h22b4;
  logic [31:0] q, d, fa;
  logic [31:0] lines[$];
  logic cache_on = 1'b0;

  always #5 clock_i = ~clock_i;

  sccp_regs DUT (.clock_i(clock_i), .arst_n_i(arst_n_i), .xfer_i(xfer_i),
    .xfer_done_o(xfer_done_o), .xfer_undef_o(xfer_undef_o), .xfer_rdata_o(xfer_rdata_o),
    .ctrl_o(ctrl_o), .ttb_o(ttb_o), .dac_o(dac_o), .tlb_flush_o(tlb_flush_o),
    .tlb_purge_o(tlb_purge_o), .tlb_purge_addr_o(tlb_purge_addr_o), .dfault_i(dfault_i),
    .dfault_prefetch_i(dfault_prefetch_i), .dfault_status_i(dfault_status_i),
    .dfault_addr_i(dfault_addr_i), .rd_valid_i(rd_valid_i), .rd_addr_i(rd_addr_i),
    .rd_cacheable_i(rd_cacheable_i), .rd_ready_o(rd_ready_o), .rd_done_o(rd_done_o),
    .rd_data_o(rd_data_o), .mem_req_o(mem_req_o), .mem_line_o(mem_line_o),
    .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i));

  sccp_mem_model mem (.clock_i(clock_i), .arst_n_i(arst_n_i), .slow_i(slow),
    .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i),
    .mem_rdata_o(mem_rdata_i));

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // one register transfer; trap or completion is due exactly one edge later
  task automatic xfer(input logic w, input logic u, input logic [3:0] n,
      input logic [31:0] wd, output logic [31:0] rq);
    logic bad;
    bad = u | n[3];
    @(posedge clock_i);
    xfer_i <= '{1'b1, w, u, n, wd};
    @(posedge clock_i);
    xfer_i.valid <= 1'b0;
    #1;
    `CHK("undef", bad, xfer_undef_o)
    `CHK("done", ~bad, xfer_done_o)
    rq = xfer_rdata_o;
  endtask

  // one cache read; the shadow model predicts the beat count and the word
  task automatic rd(input logic [31:0] a, input logic cab);
    int acks, exp_acks, i;
    logic hit;
    hit = 1'b0;
    foreach (lines[k]) if (lines[k] == {a[31:4], 4'h0}) hit = 1'b1;
    exp_acks = hit ? 0 : ((cache_on && cab) ? 4 : 1);
    if (!hit && cache_on && cab) lines.push_back({a[31:4], 4'h0});
    acks = 0;
    @(posedge clock_i);
    rd_valid_i <= 1'b1;
    rd_addr_i <= a;
    rd_cacheable_i <= cab;
    for (i = 0; i < 60; i++) begin
      @(posedge clock_i);
      rd_valid_i <= 1'b0;
      if (mem_ack_i) begin
        `CHK("line", exp_acks == 4, mem_line_o)
        `CHK("beat_a", {a[31:4], ((exp_acks == 4) ? 2'(acks) : a[3:2]), 2'b00}, mem_addr_o)
        acks++;
      end
      if (rd_done_o) break;
    end
    if (i == 60) begin
      fail_count++;
      finish_test();
    end
    `CHK("beats", exp_acks, acks)
    `CHK("req_end", 1'b0, mem_req_o)
    `CHK("rd_data", {a[15:2], 2'b00, ~a[15:2], 2'b11}, rd_data_o)
  endtask

  task automatic set_ctrl(input logic [31:0] v);
    xfer(1'b1, 1'b0, REG_SYSTEM_CONTROL, v, q);
    cache_on = v[2];
    `CHK("ctrl", {v[9], v[8], v[7], v[5:0]}, ctrl_o)
  endtask

  task automatic fault(input logic pf, input logic [7:0] st, input logic [31:0] a);
    @(posedge clock_i);
    dfault_i <= 1'b1;
    dfault_prefetch_i <= pf;
    dfault_status_i <= st;
    dfault_addr_i <= a;
    @(posedge clock_i);
    dfault_i <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence

  initial begin
    repeat (20) @(posedge clock_i);
    arst_n_i <= 1'b1;
    #1;
    `CHK("ctrl_rst", 9'h000, ctrl_o)
    `CHK("ready_rst", 1'b1, rd_ready_o)
    $display("test reset done");

    // refusals: user mode everywhere, and numbers 8 to 15 in any mode
    for (int n = 0; n < 16; n++) begin
      xfer(n[0], 1'b1, n[3:0], 32'hFFFF_FFFF, q);
      xfer(n[1], 1'b0, 4'h8 | n[3:0], 32'hFFFF_FFFF, q);
    end
    `CHK("ctrl_keep", 9'h000, ctrl_o)
    $display("test refusals done");

    // identity, also after a reserved write
    xfer(1'b0, 1'b0, REG_CHIP_IDENTITY, 32'h0, q);
    `CHK("ident", CHIP_IDENTITY_VALUE, q)
    xfer(1'b1, 1'b0, REG_CHIP_IDENTITY, 32'h1234_5678, q);
    xfer(1'b0, 1'b0, REG_CHIP_IDENTITY, 32'h0, q);
    `CHK("ident2", CHIP_IDENTITY_VALUE, q)
    $display("test identity done");

    // random control values in bits 10:0, table base values with the low 14 bits zero, and any domain value
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      d = seed & 32'h0000_07FF;
      set_ctrl(d);
      seed = lfsr(seed);
      xfer(1'b1, 1'b0, REG_TRANSLATION_TABLE_BASE, seed & 32'hFFFF_C000, q);
      `CHK("ttb", seed & 32'hFFFF_C000, ttb_o)
      seed = lfsr(seed);
      xfer(1'b1, 1'b0, REG_DOMAIN_ACCESS_CONTROL, seed, q);
      `CHK("dac", seed, dac_o)
      // reserved reads and the unused slot change nothing
      for (int n = 1; n < 8; n++) begin
        if (n == 5 || n == 6) continue;
        xfer(1'b0, 1'b0, n[3:0], 32'h0, q);
      end
      xfer(1'b1, 1'b0, REG_RESERVED_SLOT_FOUR, 32'hFFFF_FFFF, q);
      `CHK("ctrl_hold", {d[9], d[8], d[7], d[5:0]}, ctrl_o)
      `CHK("dac_hold", seed, dac_o)
    end
    $display("test control done");

    // data fault capture; a prefetch fault leaves it alone
    fa = 32'hCAFE_0124;
    fault(1'b0, 8'hA7, fa);
    xfer(1'b0, 1'b0, REG_FAULT_ADDRESS_TLB_PURGE, 32'h0, q);
    `CHK("far", fa, q)
    fault(1'b1, 8'h3C, 32'h0BAD_0000);
    xfer(1'b0, 1'b0, REG_FAULT_STATUS_TLB_FLUSH, 32'h0, q);
    `CHK("fsr", 12'h0A7, q[11:0])
    xfer(1'b0, 1'b0, REG_FAULT_ADDRESS_TLB_PURGE, 32'h0, q);
    `CHK("far_keep", fa, q)
    $display("test fault done");

    // flush and purge pulses
    xfer(1'b1, 1'b0, REG_FAULT_STATUS_TLB_FLUSH, 32'h0, q);
    `CHK("flush", 1'b1, tlb_flush_o)
    xfer(1'b1, 1'b0, REG_FAULT_ADDRESS_TLB_PURGE, 32'h0004_5000, q);
    `CHK("purge", 1'b1, tlb_purge_o)
    `CHK("purge_a", 32'h0004_5000, tlb_purge_addr_o)
    `CHK("flush_off", 1'b0, tlb_flush_o)
    $display("test tlb done");

    // cache: translation and cache on together, four lines in four sets
    // the fill way is random, so one line per set keeps the hits predictable
    set_ctrl(32'h0000_0005);
    for (int k = 0; k < 4; k++) begin
      slow = k[0];
      rd(32'h0001_0028 + k * 32'h810, 1'b1);
    end
    for (int k = 0; k < 4; k++) rd(32'h0001_0024 + k * 32'h810, 1'b1);
    // same set as the first line, other tag: must miss
    rd(32'h0001_1028, 1'b0);
    rd(32'h0002_0104, 1'b0);
    rd(32'h0002_0104, 1'b0);
    // disabled cache still serves hits until flushed
    set_ctrl(32'h0000_0001);
    rd(32'h0001_002C, 1'b1);
    xfer(1'b1, 1'b0, REG_CACHE_INVALIDATE_ALL, 32'h0, q);
    lines.delete();
    rd(32'h0001_0020, 1'b1);
    set_ctrl(32'h0000_0005);
    rd(32'h0001_0020, 1'b1);
    $display("test cache done");
    finish_test();
  end
endmodule
